// >>> pmrc_pkg.sv
// Functional notes
// - Enable bit 15 drives reference pin
// - Divisor field divides base by power two
// - Select bit 12 picks primary or system
// - Sleep-run bit 13 keeps reference in sleep
// - Sleep reference needs both bits, primary mode
// - System base follows clock switches
// - Bit 14, bits 7-0 read zero; reset zero
// - Sleep stops system clock and oscillator
// - Sleep freezes pin directions and levels
// - Clock failure monitor off in sleep
// - Sleep keeps low-power RC for watchdog/calendar
// - Watchdog cleared before sleep entry
// - Sleep disables system-clocked peripherals
// - Wake on interrupt, reset, watchdog timeout
// - Wake resumes with same clock source
// - Idle stops CPU, keeps system clock
// - Idle clears watchdog, keeps RC when needed
// - Idle exit restores CPU clock at once
// - Deep sleep stops all but calendar, watchdog; code also stops the low-power RC and ignores watchdog timeout
// - High byte unlocked by 0x78 then 0x9A
// - Switch start unlocked by 0x46 then 0x57
// - Interrupt during entry held, then wakes; code wakes from idle or sleep only, not deep sleep
`default_nettype none
package pmrc_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] OFF_REF = 8'h00;
    localparam logic [7:0] OFF_OSC = 8'h04;
    localparam logic [7:0] OFF_PWR = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    // Reference control field positions
    localparam int REF_EN_BIT = 15;
    localparam int REF_SLP_BIT = 13;
    localparam int REF_SEL_BIT = 12;
    localparam int REF_DIV_LSB = 8;
    localparam int REF_DIV_W = 4;
    localparam int REF_CNT_W = 15;
    // Oscillator control field positions
    localparam int OSC_CUR_LSB = 12;
    localparam int OSC_NEW_LSB = 8;
    localparam int OSC_SEL_W = 3;
    localparam int OSC_SW_BIT = 0;
    localparam logic [2:0] OSC_PRIMARY = 3'h2;
    localparam logic [2:0] OSC_RESET = 3'h0;
    // Unlock keys per byte
    localparam logic [7:0] KEY_HI_A = 8'h78;
    localparam logic [7:0] KEY_HI_B = 8'h9A;
    localparam logic [7:0] KEY_LO_A = 8'h46;
    localparam logic [7:0] KEY_LO_B = 8'h57;
    // Power control and command fields
    localparam int PWR_ARM_BIT = 15;
    localparam int CMD_IDLE_BIT = 0;
    localparam int STAT_SW_BIT = 4;
    // Power modes
    typedef enum logic [3:0] {
        PM_RUN = 4'h1,
        PM_IDLE = 4'h2,
        PM_SLEEP = 4'h4,
        PM_DEEP = 4'h8
    } pmrc_mode_t;
    // Unlock sequence progress
    typedef enum logic [2:0] {
        KEY_IDLE = 3'h1,
        KEY_HALF = 3'h2,
        KEY_OPEN = 3'h4
    } pmrc_key_t;
    // Reference control contents
    typedef struct packed {
        logic enable;
        logic sleep_run;
        logic base_sel;
        logic [REF_DIV_W-1:0] div;
    } pmrc_ref_t;
    // Divider state
    typedef struct packed {
        logic [REF_CNT_W-1:0] cnt;
        logic out;
    } pmrc_div_t;
    // Clock and power outputs
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic sys_osc_run;
        logic posc_run;
        logic low_power_rc_osc_run;
        logic clock_failure_monitor_active;
        logic io_freeze;
        logic mem_power_on;
        logic calendar_run;
        logic ref_drive;
    } pmrc_pwr_t;
    // Whole state of the top block
    typedef struct packed {
        pmrc_mode_t mode;
        pmrc_ref_t refc;
        pmrc_key_t key_hi;
        pmrc_key_t key_lo;
        logic [OSC_SEL_W-1:0] new_osc;
        logic [OSC_SEL_W-1:0] cur_osc;
        logic switch_start;
        logic deep_arm;
        logic wake_pend;
        logic wdt_clear;
        pmrc_pwr_t pwr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pmrc_state_t;
endpackage
`default_nettype wire

// >>> pmrc_refdiv.sv
`timescale 1ns/1ps
`default_nettype none
module pmrc_refdiv #(
    parameter int DIV_W = 4,
    parameter int CNT_W = 15
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clear,
    input wire logic tick,
    input wire logic [DIV_W-1:0] div_sel,
    // Divided output
    output logic ref_out
);
    pmrc_pkg::pmrc_div_t st;
    pmrc_pkg::pmrc_div_t next_st;

    // Counter of base ticks; each bit is a power-of-two division
    always_comb
    begin
        next_st = st;
        if (clear)
        begin
            // Held low and restarted so re-enable is glitch free
            next_st.cnt = '0;
            next_st.out = 1'b0;
        end
        else
        begin
            if (tick)
            begin
                next_st.cnt = st.cnt + 1'b1;
            end
            // Code zero passes each base tick straight through
            if (div_sel == '0)
            begin
                next_st.out = tick;
            end
            else
            begin
                next_st.out = next_st.cnt[div_sel - 1'b1];
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign ref_out = st.out;
endmodule
`default_nettype wire

// >>> pmrc_top.sv
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pmrc_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Base clock ticks
    input wire logic sys_tick,
    input wire logic posc_tick,
    // Wake and configuration inputs
    input wire logic irq_wake,
    input wire logic wdt_timeout,
    input wire logic wdt_enable,
    input wire logic clock_failure_monitor_enable,
    input wire logic calendar_enable,
    input wire logic calendar_on_low_power_rc_osc,
    // Reference pin
    output logic ref_clock_pin,
    output logic ref_pin_drive,
    // Clock and power controls
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic sys_osc_run,
    output logic posc_run,
    output logic low_power_rc_osc_run,
    output logic clock_failure_monitor_active,
    output logic io_freeze,
    output logic mem_power_on,
    output logic calendar_run,
    output logic wdt_clear,
    output logic [2:0] sys_clk_sel
);
    pmrc_pkg::pmrc_state_t st;
    pmrc_pkg::pmrc_state_t next_st;

    // Bus decode helpers
    logic setup;
    logic access;
    logic [7:0] addr8;
    logic wr_ref;
    logic wr_osc_hi;
    logic wr_osc_lo;
    logic wr_pwr;
    logic wr_cmd;
    logic enter_cmd;
    logic [15:0] ref_word;
    // Reference datapath
    logic base_tick;
    logic ref_active;
    logic sleep_ref_ok;

    assign setup = psel && !penable;
    assign access = psel && penable && st.pready;
    assign addr8 = 8'(paddr);
    assign wr_ref = access && pwrite && addr8 == pmrc_pkg::OFF_REF;
    assign wr_osc_hi = access && pwrite && addr8 == pmrc_pkg::OFF_OSC && pstrb[1];
    assign wr_osc_lo = access && pwrite && addr8 == pmrc_pkg::OFF_OSC && pstrb[0];
    assign wr_pwr = access && pwrite && addr8 == pmrc_pkg::OFF_PWR && pstrb[1];
    assign wr_cmd = access && pwrite && addr8 == pmrc_pkg::OFF_CMD && pstrb[0];
    // Power-save command only means something while the CPU runs
    assign enter_cmd = wr_cmd && st.mode == pmrc_pkg::PM_RUN;

    // Readback image; unimplemented bits stay zero
    always_comb
    begin
        ref_word = 16'h0000;
        ref_word[pmrc_pkg::REF_EN_BIT] = st.refc.enable;
        ref_word[pmrc_pkg::REF_SLP_BIT] = st.refc.sleep_run;
        ref_word[pmrc_pkg::REF_SEL_BIT] = st.refc.base_sel;
        ref_word[pmrc_pkg::REF_DIV_LSB +: pmrc_pkg::REF_DIV_W] = st.refc.div;
    end

    // Sleep reference only with primary base, sleep-run and primary mode
    assign sleep_ref_ok = st.refc.sleep_run && st.refc.base_sel
        && st.cur_osc == pmrc_pkg::OSC_PRIMARY;

    // Base clock choice; a stopped source yields no ticks
    assign base_tick = st.refc.base_sel ? (posc_tick && st.pwr.posc_run)
        : (sys_tick && st.pwr.sys_osc_run);

    // Pin runs only when enabled and the mode allows it
    assign ref_active = st.pwr.ref_drive;

    // Next-state logic for bus, registers and power modes
    always_comb
    begin
        next_st = st;
        next_st.wdt_clear = 1'b0;
        // APB answer prepared in setup, presented in the access cycle
        next_st.pready = setup;
        next_st.pslverr = 1'b0;
        if (setup)
        begin
            next_st.prdata = 32'h0000_0000;
            unique case (addr8)
                pmrc_pkg::OFF_REF:
                begin
                    next_st.prdata[15:0] = ref_word;
                end
                pmrc_pkg::OFF_OSC:
                begin
                    next_st.prdata[pmrc_pkg::OSC_CUR_LSB +: pmrc_pkg::OSC_SEL_W] = st.cur_osc;
                    next_st.prdata[pmrc_pkg::OSC_NEW_LSB +: pmrc_pkg::OSC_SEL_W] = st.new_osc;
                    next_st.prdata[pmrc_pkg::OSC_SW_BIT] = st.switch_start;
                end
                pmrc_pkg::OFF_PWR:
                begin
                    next_st.prdata[pmrc_pkg::PWR_ARM_BIT] = st.deep_arm;
                end
                pmrc_pkg::OFF_CMD:
                begin
                    // Command register is write only
                    next_st.prdata = 32'h0000_0000;
                end
                pmrc_pkg::OFF_STAT:
                begin
                    next_st.prdata[3:0] = st.mode;
                    next_st.prdata[pmrc_pkg::STAT_SW_BIT] = st.switch_start;
                end
                default:
                begin
                    // Unmapped address answers with an error
                    next_st.pslverr = 1'b1;
                end
            endcase
        end

        // Reference control write; reserved bits are dropped
        if (wr_ref && pstrb[1])
        begin
            next_st.refc.enable = pwdata[pmrc_pkg::REF_EN_BIT];
            next_st.refc.sleep_run = pwdata[pmrc_pkg::REF_SLP_BIT];
            next_st.refc.base_sel = pwdata[pmrc_pkg::REF_SEL_BIT];
            next_st.refc.div = pwdata[pmrc_pkg::REF_DIV_LSB +: pmrc_pkg::REF_DIV_W];
        end

        // High byte: any non-key write breaks the sequence
        if (wr_osc_hi)
        begin
            unique case (st.key_hi)
                pmrc_pkg::KEY_OPEN:
                begin
                    next_st.new_osc = pwdata[pmrc_pkg::OSC_NEW_LSB +: pmrc_pkg::OSC_SEL_W];
                    next_st.key_hi = pmrc_pkg::KEY_IDLE;
                end
                pmrc_pkg::KEY_HALF:
                begin
                    next_st.key_hi = (pwdata[15:8] == pmrc_pkg::KEY_HI_B) ?
                        pmrc_pkg::KEY_OPEN : pmrc_pkg::KEY_IDLE;
                end
                pmrc_pkg::KEY_IDLE:
                begin
                    next_st.key_hi = (pwdata[15:8] == pmrc_pkg::KEY_HI_A) ?
                        pmrc_pkg::KEY_HALF : pmrc_pkg::KEY_IDLE;
                end
            endcase
        end

        // Clock switch completes one cycle after start
        if (st.switch_start)
        begin
            // Redundant switch simply aborts
            next_st.cur_osc = st.new_osc;
            next_st.switch_start = 1'b0;
        end

        // Low byte: switch start only after its own key pair
        if (wr_osc_lo)
        begin
            unique case (st.key_lo)
                pmrc_pkg::KEY_OPEN:
                begin
                    if (pwdata[pmrc_pkg::OSC_SW_BIT])
                    begin
                        next_st.switch_start = 1'b1;
                    end
                    next_st.key_lo = pmrc_pkg::KEY_IDLE;
                end
                pmrc_pkg::KEY_HALF:
                begin
                    next_st.key_lo = (pwdata[7:0] == pmrc_pkg::KEY_LO_B) ?
                        pmrc_pkg::KEY_OPEN : pmrc_pkg::KEY_IDLE;
                end
                pmrc_pkg::KEY_IDLE:
                begin
                    next_st.key_lo = (pwdata[7:0] == pmrc_pkg::KEY_LO_A) ?
                        pmrc_pkg::KEY_HALF : pmrc_pkg::KEY_IDLE;
                end
            endcase
        end

        // Deep sleep arm; software sets it ahead of the command
        if (wr_pwr)
        begin
            next_st.deep_arm = pwdata[pmrc_pkg::PWR_ARM_BIT];
        end

        // Power mode sequencing
        unique case (st.mode)
            pmrc_pkg::PM_RUN:
            begin
                next_st.wake_pend = 1'b0;
                if (enter_cmd)
                begin
                    // Event during entry is held; it wakes afterwards from idle or sleep only
                    next_st.wake_pend = irq_wake || wdt_timeout;
                    // Watchdog count cleared on the way in
                    next_st.wdt_clear = wdt_enable;
                    if (pwdata[pmrc_pkg::CMD_IDLE_BIT])
                    begin
                        next_st.mode = pmrc_pkg::PM_IDLE;
                    end
                    else if (st.deep_arm)
                    begin
                        next_st.mode = pmrc_pkg::PM_DEEP;
                    end
                    else
                    begin
                        next_st.mode = pmrc_pkg::PM_SLEEP;
                    end
                end
            end
            pmrc_pkg::PM_IDLE, pmrc_pkg::PM_SLEEP:
            begin
                // Clock source left untouched so wake resumes on it
                if (irq_wake || wdt_timeout || st.wake_pend)
                begin
                    next_st.mode = pmrc_pkg::PM_RUN;
                    next_st.wake_pend = 1'b0;
                end
            end
            pmrc_pkg::PM_DEEP:
            begin
                // Only a device reset leaves deep sleep
                next_st.mode = pmrc_pkg::PM_DEEP;
            end
        endcase

        // Outputs follow the next mode so they change with it
        next_st.pwr.cpu_clk_en = next_st.mode == pmrc_pkg::PM_RUN;
        next_st.pwr.periph_clk_en = next_st.mode == pmrc_pkg::PM_RUN
            || next_st.mode == pmrc_pkg::PM_IDLE;
        next_st.pwr.sys_osc_run = next_st.pwr.periph_clk_en;
        next_st.pwr.clock_failure_monitor_active = clock_failure_monitor_enable && next_st.pwr.periph_clk_en;
        next_st.pwr.io_freeze = next_st.mode == pmrc_pkg::PM_SLEEP
            || next_st.mode == pmrc_pkg::PM_DEEP;
        next_st.pwr.mem_power_on = next_st.mode != pmrc_pkg::PM_DEEP;
        next_st.pwr.calendar_run = calendar_enable;
        unique case (next_st.mode)
            pmrc_pkg::PM_RUN:
            begin
                next_st.pwr.posc_run = next_st.cur_osc == pmrc_pkg::OSC_PRIMARY
                    || next_st.refc.base_sel;
                next_st.pwr.low_power_rc_osc_run = wdt_enable || clock_failure_monitor_enable
                    || (calendar_enable && calendar_on_low_power_rc_osc);
                next_st.pwr.ref_drive = next_st.refc.enable;
            end
            pmrc_pkg::PM_IDLE:
            begin
                next_st.pwr.posc_run = next_st.cur_osc == pmrc_pkg::OSC_PRIMARY
                    || next_st.refc.base_sel;
                next_st.pwr.low_power_rc_osc_run = wdt_enable || clock_failure_monitor_enable
                    || (calendar_enable && calendar_on_low_power_rc_osc);
                next_st.pwr.ref_drive = next_st.refc.enable;
            end
            pmrc_pkg::PM_SLEEP:
            begin
                // Crystal kept alive only for a sleeping reference
                next_st.pwr.posc_run = sleep_ref_ok && next_st.refc.enable;
                next_st.pwr.low_power_rc_osc_run = wdt_enable
                    || (calendar_enable && calendar_on_low_power_rc_osc);
                next_st.pwr.ref_drive = next_st.refc.enable
                    && next_st.refc.sleep_run;
            end
            pmrc_pkg::PM_DEEP:
            begin
                next_st.pwr.posc_run = 1'b0;
                next_st.pwr.low_power_rc_osc_run = 1'b0;
                next_st.pwr.ref_drive = 1'b0;
            end
        endcase
    end

    // State register; controls clear at reset, except the run-mode clock, oscillator and memory power enables, which are set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.mode <= pmrc_pkg::PM_RUN;
            st.key_hi <= pmrc_pkg::KEY_IDLE;
            st.key_lo <= pmrc_pkg::KEY_IDLE;
            st.new_osc <= pmrc_pkg::OSC_RESET;
            st.cur_osc <= pmrc_pkg::OSC_RESET;
            st.pwr.cpu_clk_en <= 1'b1;
            st.pwr.periph_clk_en <= 1'b1;
            st.pwr.sys_osc_run <= 1'b1;
            st.pwr.mem_power_on <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Reference divider, cleared whenever the pin is off
    pmrc_refdiv #(
        .DIV_W(pmrc_pkg::REF_DIV_W),
        .CNT_W(pmrc_pkg::REF_CNT_W)
    ) u_refdiv (
        .pclk(pclk),
        .presetn(presetn),
        .clear(!ref_active),
        .tick(base_tick),
        .div_sel(st.refc.div),
        .ref_out(ref_clock_pin)
    );

    // Output wiring from registered state
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign ref_pin_drive = st.pwr.ref_drive;
    assign cpu_clk_en = st.pwr.cpu_clk_en;
    assign periph_clk_en = st.pwr.periph_clk_en;
    assign sys_osc_run = st.pwr.sys_osc_run;
    assign posc_run = st.pwr.posc_run;
    assign low_power_rc_osc_run = st.pwr.low_power_rc_osc_run;
    assign clock_failure_monitor_active = st.pwr.clock_failure_monitor_active;
    assign io_freeze = st.pwr.io_freeze;
    assign mem_power_on = st.pwr.mem_power_on;
    assign calendar_run = st.pwr.calendar_run;
    assign wdt_clear = st.wdt_clear;
    assign sys_clk_sel = st.cur_osc;

    // Checks
    AST_REF_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !ref_active |=> !ref_clock_pin)
        else $error("reference pin not low while disabled");
    AST_RSV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        setup && addr8 == pmrc_pkg::OFF_REF |=> prdata[14] == 1'b0 && prdata[7:0] == 8'h00)
        else $error("reserved reference bits not zero");
    AST_SLEEP_OSC: assert property (@(posedge pclk) disable iff (!presetn)
        st.mode == pmrc_pkg::PM_SLEEP |-> !sys_osc_run && !cpu_clk_en && !periph_clk_en)
        else $error("system clock alive in sleep");
    AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
        enter_cmd && !pwdata[pmrc_pkg::CMD_IDLE_BIT] |=> io_freeze)
        else $error("pins not frozen on sleep entry");
    AST_CLOCK_FAILURE_MONITOR_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        st.mode == pmrc_pkg::PM_SLEEP |-> !clock_failure_monitor_active)
        else $error("clock monitor active in sleep");
    AST_WDT_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        enter_cmd && wdt_enable |=> wdt_clear ##1 !wdt_clear)
        else $error("watchdog not cleared on entry");
    AST_IDLE_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
        st.mode == pmrc_pkg::PM_IDLE && irq_wake |=> cpu_clk_en && sys_clk_sel == $past(st.cur_osc))
        else $error("idle wake did not restore cpu clock");
    AST_HI_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        wr_osc_hi && st.key_hi != pmrc_pkg::KEY_OPEN |=> $stable(st.new_osc))
        else $error("oscillator select written while locked");
    AST_LO_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        wr_osc_lo && st.key_lo != pmrc_pkg::KEY_OPEN && !st.switch_start |=> !st.switch_start)
        else $error("switch start set while locked");
    AST_POSC_SLP: assert property (@(posedge pclk) disable iff (!presetn)
        st.mode == pmrc_pkg::PM_SLEEP && !sleep_ref_ok |-> !posc_run)
        else $error("crystal kept running in sleep");
    AST_HELD_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        enter_cmd && irq_wake && !pwdata[pmrc_pkg::CMD_IDLE_BIT] && !st.deep_arm
        |=> st.mode == pmrc_pkg::PM_SLEEP ##1 st.mode == pmrc_pkg::PM_RUN)
        else $error("coincident interrupt lost");
    COV_SLEEP: cover property (@(posedge pclk) disable iff (!presetn)
        st.mode == pmrc_pkg::PM_SLEEP ##[1:20] st.mode == pmrc_pkg::PM_RUN);
    COV_IDLE: cover property (@(posedge pclk) disable iff (!presetn)
        st.mode == pmrc_pkg::PM_IDLE);
    COV_DEEP: cover property (@(posedge pclk) disable iff (!presetn)
        st.mode == pmrc_pkg::PM_DEEP);
    COV_SWITCH: cover property (@(posedge pclk) disable iff (!presetn)
        st.switch_start && st.new_osc != st.cur_osc);
endmodule
`default_nettype wire

// >>> pmrc_ext_dev.sv
`timescale 1ns/1ps
`default_nettype none
module pmrc_ext_dev (
    // Clock
    input wire logic pclk,
    // Reference pin and its output enable
    input wire logic pin,
    input wire logic drive,
    // Cycles between the last two rising edges
    output logic [15:0] period
);
    logic prev = 1'b0; // Pin one cycle back
    logic [15:0] cnt = 16'h0000; // Cycles since last edge
    // Time rising edges; an undriven pin is ignored like a real load would
    always_ff @(posedge pclk)
    begin
        prev <= pin;
        cnt <= cnt + 16'h0001;
        if (drive && pin && !prev)
        begin
            period <= cnt;
            cnt <= 16'h0001;
        end
    end
endmodule
`default_nettype wire

// >>> power_mode_refclk_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_refclk_control_test;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, err, irq_wake = 1'b0, wdt_enable = 1'b1;
    logic posc_run, mem_power_on;
    logic [1:0] tk = 2'h0; // Base tick phase
    logic ref_clock_pin, ref_pin_drive, cpu_clk_en, periph_clk_en, io_freeze, wdt_clear;
    logic [2:0] sys_clk_sel;
    logic [15:0] period;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    // Clock at 10 MHz; system ticks every second cycle, primary every fourth
    always #50 pclk = ~pclk;
    always @(posedge pclk) tk <= tk + 2'h1;
    pmrc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sys_tick(tk[0]), .posc_tick(&tk),
        .irq_wake(irq_wake), .wdt_timeout(1'b0), .wdt_enable(wdt_enable),
        .clock_failure_monitor_enable(1'b0), .calendar_enable(1'b0), .calendar_on_low_power_rc_osc(1'b0),
        .ref_clock_pin(ref_clock_pin), .ref_pin_drive(ref_pin_drive),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .sys_osc_run(),
        .posc_run(posc_run), .low_power_rc_osc_run(), .clock_failure_monitor_active(), .io_freeze(io_freeze),
        .mem_power_on(mem_power_on), .calendar_run(), .wdt_clear(wdt_clear),
        .sys_clk_sel(sys_clk_sel));
    pmrc_ext_dev ext (.pclk(pclk), .pin(ref_clock_pin), .drive(ref_pin_drive), .period(period));
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; holds until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reset value, unimplemented bits, unmapped address
    task automatic t_regs;
        apb(1'b0, pmrc_pkg::OFF_REF, 32'h0);
        check("ref reset", rd, 32'h0);
        apb(1'b1, pmrc_pkg::OFF_REF, 32'hFFFFFFFF);
        apb(1'b0, pmrc_pkg::OFF_REF, 32'h0);
        check("ref bits", rd, 32'h0000BF00);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped", err, 32'h1);
        apb(1'b1, pmrc_pkg::OFF_REF, 32'h0);
        repeat (3) @(posedge pclk);
        check("pin off", {ref_clock_pin, ref_pin_drive}, 32'h0);
    endtask
    // Divider period for each base and a few divisor codes
    task automatic t_div;
        for (int k = 0; k < 6; k++)
        begin
            apb(1'b1, pmrc_pkg::OFF_REF, {16'h0, 1'b1, 2'b00, k[0], k[4:1], 8'h00});
            repeat (70) @(posedge pclk);
            check("period", period, (32'h2 << k[4:1]) << k[0]);
        end
    endtask
    // Idle then sleep entry, outputs, wake on interrupt
    task automatic t_pwr;
        apb(1'b1, pmrc_pkg::OFF_REF, 32'h0000B000);
        for (int d = 1; d >= 0; d--)
        begin
            apb(1'b1, pmrc_pkg::OFF_CMD, d);
            @(negedge pclk);
            check("cpu", cpu_clk_en, 32'h0);
            check("periph", periph_clk_en, d);
            check("freeze", io_freeze, 1 - d);
            check("wdt clr", wdt_clear, 32'h1);
            check("ref drive", ref_pin_drive, 32'h1);
            @(posedge pclk);
            irq_wake <= 1'b1;
            @(posedge pclk);
            irq_wake <= 1'b0;
            @(negedge pclk);
            check("wake", cpu_clk_en, 32'h1);
            check("clk src", sys_clk_sel, 32'h0);
        end
        // Interrupt in the entry cycle is held, then wakes
        @(posedge pclk);
        irq_wake <= 1'b1;
        apb(1'b1, pmrc_pkg::OFF_CMD, 32'h0);
        irq_wake <= 1'b0;
        @(negedge pclk);
        check("held sleep", io_freeze, 32'h1);
        @(negedge pclk);
        check("held wake", cpu_clk_en, 32'h1);
    endtask
    // Oscillator select and switch start behind their keys
    task automatic t_osc;
        apb(1'b1, pmrc_pkg::OFF_OSC, 32'h00000201);
        apb(1'b0, pmrc_pkg::OFF_OSC, 32'h0);
        check("osc locked", rd, 32'h0);
        apb(1'b1, pmrc_pkg::OFF_OSC, 32'h00007800);
        apb(1'b1, pmrc_pkg::OFF_OSC, 32'h00009A00);
        apb(1'b1, pmrc_pkg::OFF_OSC, {21'h0, pmrc_pkg::OSC_PRIMARY, 8'h00});
        apb(1'b1, pmrc_pkg::OFF_OSC, 32'h00000046);
        apb(1'b1, pmrc_pkg::OFF_OSC, 32'h00000057);
        apb(1'b1, pmrc_pkg::OFF_OSC, 32'h00000001);
        apb(1'b0, pmrc_pkg::OFF_OSC, 32'h0);
        check("osc switched", rd, {17'h0, pmrc_pkg::OSC_PRIMARY, 1'b0,
            pmrc_pkg::OSC_PRIMARY, 8'h00});
        // Sleeping reference on the crystal, wake keeps the source
        apb(1'b1, pmrc_pkg::OFF_CMD, 32'h0);
        @(negedge pclk);
        check("posc sleep", posc_run, 32'h1);
        @(posedge pclk);
        irq_wake <= 1'b1;
        @(posedge pclk);
        irq_wake <= 1'b0;
        @(negedge pclk);
        check("resume src", sys_clk_sel, 32'(pmrc_pkg::OSC_PRIMARY));
    endtask
    // Deep sleep ignores interrupts; a mid-run reset brings back run
    task automatic t_deep;
        apb(1'b1, pmrc_pkg::OFF_PWR, 32'h00008000);
        apb(1'b1, pmrc_pkg::OFF_CMD, 32'h0);
        @(posedge pclk);
        irq_wake <= 1'b1;
        @(posedge pclk);
        irq_wake <= 1'b0;
        @(negedge pclk);
        check("deep", {cpu_clk_en, mem_power_on, ref_pin_drive, io_freeze}, 32'h1);
        apb(1'b0, pmrc_pkg::OFF_STAT, 32'h0);
        check("deep stat", rd, 32'h8);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check("reset exit", {cpu_clk_en, mem_power_on, sys_clk_sel}, 32'h18);
        apb(1'b0, pmrc_pkg::OFF_PWR, 32'h0);
        check("arm clear", rd, 32'h0);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_div();
        t_pwr();
        t_osc();
        t_deep();
        report_and_stop();
    end
endmodule
`default_nettype wire
